// *** include/cmpe_map.svh ***
// Register offsets, field positions and reset values of the comparator
// event block. Assumes APB with 32-bit data and word-aligned registers.
// Notes on behaviour
// - ADC trigger select: six choices per comparator
// - Interrupt condition select: five choices
// - Interrupt and ADC trigger detection independent
// - Reference source: own pin, pin zero, internal
// - Output pin, true or inverted polarity
// - Interrupt enable gates the processor line
// - Software clear removes latched interrupt
// - Level interrupt persists while level holds
// - Several comparators, indexed, sharing references
// - Raw and masked interrupt status readable
// - Present output level readable
`ifndef CMPE_MAP_SVH
`define CMPE_MAP_SVH
`define CMPE_NUM 3
`define CMPE_ADDR_W 8
`define CMPE_OFF_RAW 8'h00
`define CMPE_OFF_MASKED 8'h04
`define CMPE_OFF_ENABLE 8'h08
`define CMPE_OFF_VALUE 8'h0C
`define CMPE_OFF_CFG0 8'h20
`define CMPE_CFG_STRIDE 8'h04
`define CMPE_CFG_TRIG_LSB 0
`define CMPE_CFG_INT_LSB 4
`define CMPE_CFG_REF_LSB 8
`define CMPE_CFG_INV_BIT 12
`define CMPE_CFG_RESET 32'h0000_0000
`endif

// *** include/cmpe_pkg.sv ***
// Types of the comparator event block.
// Assumes cmpe_map.svh for the numbers.
`default_nettype none
package cmpe_pkg;
    typedef enum logic [2:0] {
        adc_trigger_off = 3'h0,
        adc_trigger_level_high = 3'h1,
        adc_trigger_level_low = 3'h2,
        adc_trigger_falling = 3'h3,
        adc_trigger_rising = 3'h4,
        adc_trigger_any_edge = 3'h5
    } cmpe_trig_t;
    typedef enum logic [2:0] {
        int_level_high = 3'h0,
        int_level_low = 3'h1,
        int_falling = 3'h2,
        int_rising = 3'h3,
        int_any_edge = 3'h4
    } cmpe_int_t;
    typedef enum logic [1:0] {
        ref_own_pin = 2'h0,
        ref_shared_pin_zero = 2'h1,
        ref_internal = 2'h2
    } cmpe_ref_t;
    typedef struct packed {
        logic invert;
        cmpe_ref_t reference_source_select;
        cmpe_int_t int_select;
        cmpe_trig_t adc_trigger_select;
    } cmpe_cfg_t;
endpackage
`default_nettype wire

// *** hdl/cmpe_top.sv ***
// Comparator event logic: config, sync, detection, status over APB.
// Assumes analog comparators outside; their outputs are asynchronous.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cmpe_map.svh"
module cmpe_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog side
    input wire logic [`CMPE_NUM-1:0] comp_raw,
    output logic [`CMPE_NUM-1:0] ref_use_own_pin,
    output logic [`CMPE_NUM-1:0] ref_use_pin_zero,
    output logic [`CMPE_NUM-1:0] ref_use_internal,
    // Output pins, ADC and processor
    output logic [`CMPE_NUM-1:0] comp_pin_out,
    output logic [`CMPE_NUM-1:0] adc_trigger,
    output logic irq
);
    localparam int N = `CMPE_NUM;
    cmpe_pkg::cmpe_cfg_t cfg [N];
    logic [N-1:0] sync1, sync2, prev, raw, enable;
    logic [N-1:0] rise, fall, int_hit, next_raw;
    logic wr, rd_ok;
    logic [`CMPE_ADDR_W-1:0] a;

    // Zero-wait slave; every access completes in its access phase
    assign pready = 1'b1;
    assign a = paddr[`CMPE_ADDR_W-1:0];
    assign wr = psel && penable && pwrite;

    // Two-flop synchroniser; sync1 feeds only sync2
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= comp_raw;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Edge pulses last one cycle per transition
    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;

    // Per-comparator decode and trigger, one shared internal reference
    for (genvar i = 0; i < N; i++) begin : g_comp
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cfg[i] <= cmpe_pkg::cmpe_cfg_t'(9'(`CMPE_CFG_RESET));
            end else if (wr && a == `CMPE_OFF_CFG0 + 8'(i * 4)) begin
                cfg[i].adc_trigger_select <= cmpe_pkg::cmpe_trig_t'(
                    pwdata[`CMPE_CFG_TRIG_LSB +: 3]);
                cfg[i].int_select <= cmpe_pkg::cmpe_int_t'(
                    pwdata[`CMPE_CFG_INT_LSB +: 3]);
                cfg[i].reference_source_select <= cmpe_pkg::cmpe_ref_t'(
                    pwdata[`CMPE_CFG_REF_LSB +: 2]);
                cfg[i].invert <= pwdata[`CMPE_CFG_INV_BIT];
            end
        end

        // Comparator zero's shared pin is its own pin
        assign ref_use_own_pin[i] = cfg[i].reference_source_select ==
            cmpe_pkg::ref_own_pin || (i == 0 &&
            cfg[i].reference_source_select == cmpe_pkg::ref_shared_pin_zero);
        assign ref_use_pin_zero[i] = i != 0 &&
            cfg[i].reference_source_select == cmpe_pkg::ref_shared_pin_zero;
        assign ref_use_internal[i] = cfg[i].reference_source_select ==
            cmpe_pkg::ref_internal;

        // Interrupt condition, separate from trigger selection
        always_comb begin
            case (cfg[i].int_select)
                cmpe_pkg::int_level_high: int_hit[i] = sync2[i];
                cmpe_pkg::int_level_low: int_hit[i] = ~sync2[i];
                cmpe_pkg::int_falling: int_hit[i] = fall[i];
                cmpe_pkg::int_rising: int_hit[i] = rise[i];
                cmpe_pkg::int_any_edge: int_hit[i] = rise[i] | fall[i];
                default: int_hit[i] = 1'b0;
            endcase
        end

        // Trigger registered so the ADC sees a clean flop output
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                adc_trigger[i] <= 1'b0;
                comp_pin_out[i] <= 1'b0;
            end else begin
                comp_pin_out[i] <= sync2[i] ^ cfg[i].invert;
                case (cfg[i].adc_trigger_select)
                    cmpe_pkg::adc_trigger_off: adc_trigger[i] <= 1'b0;
                    cmpe_pkg::adc_trigger_level_high:
                        adc_trigger[i] <= sync2[i];
                    cmpe_pkg::adc_trigger_level_low:
                        adc_trigger[i] <= ~sync2[i];
                    cmpe_pkg::adc_trigger_falling: adc_trigger[i] <= fall[i];
                    cmpe_pkg::adc_trigger_rising: adc_trigger[i] <= rise[i];
                    cmpe_pkg::adc_trigger_any_edge:
                        adc_trigger[i] <= rise[i] | fall[i];
                    default: adc_trigger[i] <= 1'b0;
                endcase
            end
        end
    end

    // Set wins over clear, so a held level re-asserts at once
    always_comb begin
        next_raw = raw;
        if (wr && a == `CMPE_OFF_RAW) begin
            next_raw = raw & ~pwdata[N-1:0];
        end
        next_raw = next_raw | int_hit;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            raw <= '0;
        end else begin
            raw <= next_raw;
        end
    end

    // Interrupt enable register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable <= '0;
        end else if (wr && a == `CMPE_OFF_ENABLE) begin
            enable <= pwdata[N-1:0];
        end
    end

    // Gated interrupt toward the processor
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_raw & enable);
        end
    end

    // Read decode; unmapped addresses read zero with pslverr
    always_comb begin
        prdata = 32'h0000_0000;
        rd_ok = 1'b1;
        case (a)
            `CMPE_OFF_RAW: prdata[N-1:0] = raw;
            `CMPE_OFF_MASKED: prdata[N-1:0] = raw & enable;
            `CMPE_OFF_ENABLE: prdata[N-1:0] = enable;
            `CMPE_OFF_VALUE: prdata[N-1:0] = sync2;
            default: begin
                rd_ok = 1'b0;
                for (int k = 0; k < N; k++) begin
                    if (a == `CMPE_OFF_CFG0 + 8'(k * 4)) begin
                        rd_ok = 1'b1;
                        // Same field places as a write, so it reads back
                        prdata[`CMPE_CFG_TRIG_LSB +: 3] =
                            cfg[k].adc_trigger_select;
                        prdata[`CMPE_CFG_INT_LSB +: 3] = cfg[k].int_select;
                        prdata[`CMPE_CFG_REF_LSB +: 2] =
                            cfg[k].reference_source_select;
                        prdata[`CMPE_CFG_INV_BIT] = cfg[k].invert;
                    end
                end
            end
        endcase
    end
    assign pslverr = psel && penable && !rd_ok;

    // Disabled comparators never reach the processor line
    irq_gate_a: assert property (@(posedge clock)
        disable iff (!rst_n) irq |-> |(raw & $past(enable)))
        else $error("irq without enabled pending");
    clear_level_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        (wr && a == `CMPE_OFF_RAW && pwdata[0] && !int_hit[0]) |=> !raw[0])
        else $error("clear did not remove flag");
    level_hold_a: assert property (@(posedge clock)
        disable iff (!rst_n) int_hit[1] |=> raw[1])
        else $error("level interrupt lost");
    sync_two_a: assert property (@(posedge clock)
        disable iff (!rst_n) sync2 == $past(comp_raw, 2) || $past(!rst_n, 2))
        else $error("sync depth wrong");
    rise_pulse_a: assert property (@(posedge clock)
        disable iff (!rst_n) rise[2] |=> !rise[2])
        else $error("edge pulse longer than one cycle");
    masked_read_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        a == `CMPE_OFF_MASKED |-> prdata[N-1:0] == (raw & enable))
        else $error("masked status wrong");
    value_read_a: assert property (@(posedge clock)
        disable iff (!rst_n) a == `CMPE_OFF_VALUE && !$past(!rst_n, 2)
        |-> prdata[N-1:0] == $past(comp_raw, 2))
        else $error("value read wrong");
    trig_rise_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        (cfg[2].adc_trigger_select == cmpe_pkg::adc_trigger_rising
        && $stable(cfg[2]) && rise[2]) |=> adc_trigger[2])
        else $error("rising trigger missed");
    pin_pol_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        comp_pin_out[0] == ($past(sync2[0]) ^ $past(cfg[0].invert)))
        else $error("pin polarity wrong");
    // Trigger acts on its own setting, whatever the interrupt does
    trig_off_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        cfg[2].adc_trigger_select == cmpe_pkg::adc_trigger_off
        |=> !adc_trigger[2])
        else $error("trigger while off");
    trig_low_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        cfg[2].adc_trigger_select == cmpe_pkg::adc_trigger_level_low
        |=> adc_trigger[2] == !$past(sync2[2]))
        else $error("low level trigger wrong");
    fall_pulse_a: assert property (@(posedge clock)
        disable iff (!rst_n) fall[2] |=> !fall[2])
        else $error("fall pulse longer than one cycle");
    mask_off_a: assert property (@(posedge clock)
        disable iff (!rst_n) enable == '0 |=> !irq)
        else $error("irq with all enables off");
    flag_hold_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        raw[2] && !(wr && a == `CMPE_OFF_RAW && pwdata[2]) |=> raw[2])
        else $error("flag lost without clear");
endmodule
`default_nettype wire

// *** bench/cmpe_far_side.sv ***
// Far side model: the analog comparators and the ADC sequencer.
// Assumes the bench sets wanted levels; the block sees them asynchronously.
`timescale 1ns/1ps
`default_nettype none
`include "cmpe_map.svh"
module cmpe_far_side (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Levels wanted by the bench
    input wire logic [`CMPE_NUM-1:0] lvl,
    // Towards the block
    output logic [`CMPE_NUM-1:0] comp_raw,
    input wire logic [`CMPE_NUM-1:0] adc_trigger
);
    int unsigned cnt [`CMPE_NUM];
    // Output moves 7 ns off the edge, so the sync stage sees it late
    initial comp_raw = '0;
    always @(lvl) comp_raw <= #7 lvl;
    // Sequencer counts each trigger cycle as one capture start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '{default: 0};
        end else begin
            for (int i = 0; i < `CMPE_NUM; i++) begin
                if (adc_trigger[i]) cnt[i] <= cnt[i] + 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/comparator_event_logic_bench.sv ***
// Bench for the comparator event block over APB.
// Assumes a zero-wait slave and the far-side model in cmpe_far_side.
`timescale 1ns/1ps
`default_nettype none
`include "cmpe_map.svh"
module comparator_event_logic_bench;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata;
    logic pready, pslverr, irq;
    logic [2:0] lvl = '0, comp_raw, own, pz, intl, pin, trig, v;
    logic [32:0] q[$];
    int n_mismatch = 0, tests_run = 0, cnt0;
    int tr[4] = '{0, 3, 4, 5}, ic[4] = '{3, 2, 4, 3};
    int ne[4] = '{0, 1, 1, 2}, er[4] = '{4, 0, 4, 4};
    // 20 MHz clock
    always #25 clock = ~clock;
    cmpe_top dut (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_raw(comp_raw), .ref_use_own_pin(own),
        .ref_use_pin_zero(pz), .ref_use_internal(intl),
        .comp_pin_out(pin), .adc_trigger(trig), .irq(irq));
    cmpe_far_side far (.clock(clock), .rst_n(rst_n), .lvl(lvl),
        .comp_raw(comp_raw), .adc_trigger(trig));
    task automatic chk(input string nm, input logic [32:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Setup then access; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input int d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= wr;
        paddr <= {24'h0, a}; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input int e, input logic r = 0);
        q.push_back({r, e[31:0]});
        apb(1'b0, a, 0);
    endtask
    // Oldest note is judged at the edge that completes a read
    always @(posedge clock)
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", {pslverr, prdata}, q.pop_front());
    // Watchdog: far beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(21535));
        w(5);
        rst_n <= 1;
        rd(8'h10, 0, 1'b1); // Unmapped word is refused
        rd(`CMPE_OFF_CFG0, 0);
        v = 3'($urandom);
        lvl <= v;
        w(6);
        rd(`CMPE_OFF_VALUE, int'(v));
        chk("pin", pin, v);
        for (int i = 0; i < 3; i++) apb(1, `CMPE_OFF_CFG0 + 8'(4*i), 'h1000);
        w(3);
        chk("pin inv", pin, v ^ 3'h7);
        rd(`CMPE_OFF_CFG0 + 8'h08, 'h1000);
        for (int r = 0; r < 3; r++) begin
            apb(1, `CMPE_OFF_CFG0 + 8'h04, r << 8);
            w(1);
            chk("ref", {intl[1], pz[1], own[1]}, 3'b001 << r);
        end
        apb(1, `CMPE_OFF_CFG0, 'h100);
        w(1);
        chk("ref0", own[0], 1'b1);
        lvl <= 0;
        w(6);
        apb(1, `CMPE_OFF_ENABLE, 7);
        // Edge modes on comparator 2, interrupt and trigger set apart
        for (int m = 0; m < 4; m++) begin
            apb(1, `CMPE_OFF_CFG0 + 8'h08, (ic[m] << 4) | tr[m]);
            apb(1, `CMPE_OFF_RAW, 7);
            cnt0 = far.cnt[2];
            lvl[2] <= 1;
            w(6);
            rd(`CMPE_OFF_RAW, er[m]);
            lvl[2] <= 0;
            w(6);
            rd(`CMPE_OFF_RAW, 4);
            chk("trig count", far.cnt[2] - cnt0, ne[m]);
            chk("irq", irq, 1'b1);
        end
        for (int t = 1; t < 3; t++) begin
            apb(1, `CMPE_OFF_CFG0 + 8'h08, t);
            lvl[2] <= 1;
            w(5);
            chk("trig hi", trig[2], t == 1);
            lvl[2] <= 0;
            w(5);
            chk("trig lo", trig[2], t == 2);
        end
        lvl[1] <= 1;
        w(6);
        apb(1, `CMPE_OFF_RAW, 7);
        w(2);
        rd(`CMPE_OFF_RAW, 2);
        lvl[1] <= 0;
        w(6);
        apb(1, `CMPE_OFF_RAW, 7);
        rd(`CMPE_OFF_RAW, 0);
        apb(1, `CMPE_OFF_ENABLE, 0);
        lvl[1] <= 1;
        w(6);
        rd(`CMPE_OFF_MASKED, 0);
        rd(`CMPE_OFF_RAW, 2);
        chk("irq off", irq, 1'b0);
        apb(1, `CMPE_OFF_ENABLE, 2);
        w(2);
        rd(`CMPE_OFF_MASKED, 2);
        chk("irq on", irq, 1'b1);
        rd(`CMPE_OFF_ENABLE, 2);
        // Level-low interrupt on comparator 1, first with its level high
        apb(1, `CMPE_OFF_CFG0 + 8'h04, 'h10);
        apb(1, `CMPE_OFF_RAW, 7);
        rd(`CMPE_OFF_RAW, 0);
        lvl[1] <= 0;
        w(6);
        rd(`CMPE_OFF_RAW, 2);
        apb(1, `CMPE_OFF_RAW, 2);
        rd(`CMPE_OFF_RAW, 2);
        summarize();
    end
endmodule
`default_nettype wire
